// ==== una_ext.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "una_cfg.svh"
// Behaviour
// - abort bit stops DMA, then self-clears
// - baud generator uses 4-bit fraction register
// - ninth-bit-one character compared with address
// - after match accept ninth-bit-zero data
// - extended mode sends 9-bit, address from register
// - width bit selects 9 or 8-bit holding with the extension bit off; with it on, 8-bit holding
// - send-address picks address or queue character with the extension bit on
// - match enable turns address filtering on when the extension bit is also on
// - extension bit enables 9-bit line characters
module una_ext
(
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // dma
  input  wire logic        dmaError,
  output logic             dmaAbort,
  // transmit queue side
  input  wire logic [8:0]  txQueueData,
  input  wire logic        txQueueValid,
  output logic             txQueueTake,
  // receive queue side
  output logic      [8:0]  rxQueueData,
  output logic             rxQueueValid,
  // serial line
  input  wire logic        serialIn,
  output logic             serialOut
);
  import una_pkg::*;

  logic [15:0] divInt_q;
  logic [3:0]  divisorFraction_q;
  logic [7:0]  rxMatchAddr_q;
  logic [7:0]  txAddr_q;
  logic [3:0]  extLcr_q;
  logic        abortPend_q;
  logic        abortDone_q;
  logic        matched_q;
  logic        baudTick;
  logic        wordLengthExtend;
  logic        addrMatchEn;
  logic        sendAddr;
  logic        txWide;

  assign wordLengthExtend = extLcr_q[`UNA_EXT_WLEN_BIT];
  assign addrMatchEn      = extLcr_q[`UNA_EXT_MATCH_BIT];
  assign sendAddr         = extLcr_q[`UNA_EXT_SENDA_BIT];
  assign txWide           = extLcr_q[`UNA_EXT_TXW9_BIT];

  // fractional divisor feeds the tick generator
  una_baud_gen #(.DIV_W(16)) uBaud
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .divInt  (divInt_q),
    .divFrac (divisorFraction_q),
    .tick    (baudTick)
  );

  // register writes; the address registers are read-only on their own
  // offsets, so a separate setup word loads both
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divInt_q          <= `UNA_RST_BAUD_INT;
      divisorFraction_q <= 4'h0;
      rxMatchAddr_q     <= `UNA_RST_ZERO8;
      txAddr_q          <= `UNA_RST_ZERO8;
      extLcr_q          <= 4'h0;
    end
    else if (clkEn && regWr)
    begin
      if (regAddr == `UNA_OFF_BAUD_FRAC)
        divisorFraction_q <= regWdata[3:0];
      else if (regAddr == `UNA_OFF_EXT_LCR)
        extLcr_q <= regWdata[3:0];
      else if (regAddr == `UNA_OFF_BAUD_INT)
        divInt_q <= regWdata[15:0];
      else if (regAddr == `UNA_OFF_ADDR_SET)
      begin
        rxMatchAddr_q <= regWdata[7:0];
        txAddr_q      <= regWdata[15:8];
      end
    end
  end

  // abort: held until the dma engine has seen one pulse, then cleared
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      abortPend_q <= 1'b0;
      abortDone_q <= 1'b0;
      dmaAbort    <= 1'b0;
    end
    else if (clkEn)
    begin
      dmaAbort    <= abortPend_q && !abortDone_q; // one pulse per request
      abortDone_q <= abortPend_q;
      if (regWr && regAddr == `UNA_OFF_DMA_ABORT && regWdata[0])
        abortPend_q <= 1'b1; // a new write wins over the self-clear
      else if (abortDone_q)
        abortPend_q <= 1'b0;
    end
  end

  // read mux, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdata <= 32'h0;
    else if (clkEn)
    begin
      regRdata <= 32'h0;
      if (regRd)
      begin
        if (regAddr == `UNA_OFF_DMA_ABORT)
          regRdata <= {31'h0, abortPend_q};
        else if (regAddr == `UNA_OFF_BAUD_FRAC)
          regRdata <= {28'h0, divisorFraction_q};
        else if (regAddr == `UNA_OFF_RX_ADDR)
          regRdata <= {24'h0, rxMatchAddr_q};
        else if (regAddr == `UNA_OFF_TX_ADDR)
          regRdata <= {24'h0, txAddr_q};
        else if (regAddr == `UNA_OFF_EXT_LCR)
          regRdata <= {28'h0, extLcr_q};
        else if (regAddr == `UNA_OFF_BAUD_INT)
          regRdata <= {16'h0, divInt_q};
        else if (regAddr == `UNA_OFF_ADDR_SET)
          regRdata <= {16'h0, txAddr_q, rxMatchAddr_q};
        else if (regAddr == `UNA_OFF_STATUS)
          regRdata <= {30'h0, dmaError, matched_q};
      end
    end
  end

  // ---------------- transmitter ----------------
  una_state_t  txState_q;
  logic [3:0]  txSub_q;
  logic [3:0]  txBit_q;
  logic [8:0]  txShift_q;
  logic [3:0]  txBits;
  logic [8:0]  txChar;

  // nine bits on the line only with the extension on
  assign txBits = wordLengthExtend ? 4'h9 : 4'h8;

  // address flag picks the address register or the queue word
  always_comb
  begin
    if (wordLengthExtend && sendAddr)
      txChar = {1'b1, txAddr_q};
    else if (wordLengthExtend)
      txChar = {1'b0, txQueueData[7:0]};
    else if (txWide)
      txChar = txQueueData;
    else
      txChar = {1'b0, txQueueData[7:0]};
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txState_q   <= UNA_IDLE;
      txSub_q     <= 4'h0;
      txBit_q     <= 4'h0;
      txShift_q   <= 9'h0;
      serialOut   <= 1'b1;
      txQueueTake <= 1'b0;
    end
    else if (clkEn)
    begin
      txQueueTake <= 1'b0;
      case (txState_q)
        UNA_IDLE:
        begin
          serialOut <= 1'b1;
          // an address character needs no queue entry
          if (baudTick && (txQueueValid || (wordLengthExtend && sendAddr)))
          begin
            txShift_q   <= txChar;
            txQueueTake <= !(wordLengthExtend && sendAddr);
            txSub_q     <= 4'h0;
            txState_q   <= UNA_START;
            serialOut   <= 1'b0;
          end
        end
        UNA_START:
          if (baudTick)
          begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == 4'hf)
            begin
              serialOut <= txShift_q[0];
              txBit_q   <= 4'h0;
              txState_q <= UNA_DATA;
            end
          end
        UNA_DATA:
          if (baudTick)
          begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == 4'hf)
            begin
              if (txBit_q == txBits - 4'h1)
              begin
                serialOut <= 1'b1;
                txState_q <= UNA_STOP;
              end
              else
              begin
                txShift_q <= {1'b0, txShift_q[8:1]};
                serialOut <= txShift_q[1];
                txBit_q   <= txBit_q + 4'h1;
              end
            end
          end
        UNA_STOP:
          if (baudTick)
          begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == 4'hf)
              txState_q <= UNA_IDLE;
          end
        default:
          txState_q <= UNA_IDLE;
      endcase
    end
  end

  // ---------------- receiver ----------------
  una_state_t  rxState_q;
  logic        rxMeta_q;
  logic        rxSync_q;
  logic [3:0]  rxSub_q;
  logic [3:0]  rxBit_q;
  logic [8:0]  rxShift_q;
  logic [8:0]  rxChar;

  // line pin crosses into ref_clk domain
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end
    else if (clkEn)
    begin
      rxMeta_q <= serialIn;
      rxSync_q <= rxMeta_q;
    end
  end

  // align the final bit to bit 8 or bit 7
  assign rxChar = wordLengthExtend ? rxShift_q : {1'b0, rxShift_q[8:1]};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxState_q    <= UNA_IDLE;
      rxSub_q      <= 4'h0;
      rxBit_q      <= 4'h0;
      rxShift_q    <= 9'h0;
      rxQueueData  <= 9'h0;
      rxQueueValid <= 1'b0;
      matched_q    <= 1'b0;
    end
    else if (clkEn)
    begin
      rxQueueValid <= 1'b0;
      if (!addrMatchEn)
        matched_q <= 1'b0; // filter off: normal mode
      case (rxState_q)
        UNA_IDLE:
          if (baudTick && !rxSync_q)
          begin
            rxSub_q   <= 4'h0;
            rxState_q <= UNA_START;
          end
        UNA_START:
          if (baudTick)
          begin
            rxSub_q <= rxSub_q + 4'h1;
            if (rxSub_q == 4'h7)
            begin
              rxSub_q   <= 4'h0;
              rxBit_q   <= 4'h0;
              // glitch shorter than half a bit is dropped
              rxState_q <= rxSync_q ? UNA_IDLE : UNA_DATA;
            end
          end
        UNA_DATA:
          if (baudTick)
          begin
            rxSub_q <= rxSub_q + 4'h1;
            if (rxSub_q == 4'hf)
            begin
              rxShift_q <= {rxSync_q, rxShift_q[8:1]};
              rxBit_q   <= rxBit_q + 4'h1;
              if (rxBit_q == txBits - 4'h1)
                rxState_q <= UNA_STOP;
            end
          end
        UNA_STOP:
          begin
            rxState_q <= UNA_IDLE;
            if (wordLengthExtend && addrMatchEn)
            begin
              if (rxChar[8])
                matched_q <= (rxChar[7:0] == rxMatchAddr_q);
              else if (matched_q)
              begin
                rxQueueData  <= rxChar;
                rxQueueValid <= 1'b1;
              end
              // unmatched data is dropped here
            end
            else
            begin
              rxQueueData  <= rxChar;
              rxQueueValid <= 1'b1;
            end
          end
        default:
          rxState_q <= UNA_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== una_cfg.svh ====
`ifndef UNA_CFG_SVH
`define UNA_CFG_SVH
// register offsets (byte addresses)
`define UNA_OFF_DMA_ABORT   8'ha8
`define UNA_OFF_BAUD_FRAC   8'hc0
`define UNA_OFF_RX_ADDR     8'hc4
`define UNA_OFF_TX_ADDR     8'hc8
`define UNA_OFF_EXT_LCR     8'hcc
// integer divisor, address setup and status (chosen offsets)
`define UNA_OFF_BAUD_INT    8'hd0
`define UNA_OFF_ADDR_SET    8'hd4
`define UNA_OFF_STATUS      8'hd8
// extended line control fields
`define UNA_EXT_WLEN_BIT    0
`define UNA_EXT_MATCH_BIT   1
`define UNA_EXT_SENDA_BIT   2
`define UNA_EXT_TXW9_BIT    3
// reset values
`define UNA_RST_BAUD_INT    16'h0001
`define UNA_RST_ZERO8       8'h00
`endif

// ==== una_pkg.sv ====
package una_pkg;
  typedef enum logic [3:0]
  {
    UNA_IDLE  = 4'b0001,
    UNA_START = 4'b0010,
    UNA_DATA  = 4'b0100,
    UNA_STOP  = 4'b1000
  } una_state_t;
endpackage

// ==== una_baud_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
// 16x oversample tick with 4-bit fractional accumulation
module una_baud_gen
#(
  parameter int DIV_W = 16
)
(
  // clocking
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  // divisor
  input  wire logic [DIV_W-1:0] divInt,
  input  wire logic [3:0]       divFrac,
  // tick out
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [3:0]       acc_q;
  logic [4:0]       accSum;
  logic             extra;

  // refused at elaboration: the counter needs room for a divisor above one
  if (DIV_W < 2)
  begin : gBadWidth
    $error("DIV_W too small");
  end

  assign accSum = {1'b0, acc_q} + {1'b0, divFrac};
  assign extra  = accSum[4];

  // a carry of the fraction stretches one period by a cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      acc_q <= 4'h0;
      tick  <= 1'b0;
    end
    else if (clkEn)
    begin
      tick <= 1'b0;
      if (divInt == '0)
        cnt_q <= '0; // divisor zero holds the generator still
      else if (cnt_q >= divInt - DIV_W'(1) + (extra ? DIV_W'(1) : DIV_W'(0)))
      begin
        cnt_q <= '0;
        acc_q <= accSum[3:0];
        tick  <= 1'b1;
      end
      else
        cnt_q <= cnt_q + DIV_W'(1);
    end
  end
endmodule
`default_nettype wire

// ==== una_ext_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
// watches the extension block from its ports only
module una_ext_assertions
(
  // clocking
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // dma and line
  input wire logic        dmaAbort,
  input wire logic        txQueueTake,
  input wire logic        rxQueueValid,
  input wire logic        serialOut
);
  logic abortReq;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // abort request as the bus presents it
  assign abortReq = clkEn && regWr && regAddr == 8'ha8 && regWdata[0];
  sequence s_abortWr;
    abortReq ##1 !regWr;
  endsequence
  sequence s_abortPulse;
    dmaAbort ##1 !dmaAbort;
  endsequence
  a_abort_pulse: assert property (s_abortWr |-> ##1 s_abortPulse)
    else $error("abort pulse missing");
  a_abort_cause: assert property (dmaAbort |-> $past(abortReq, 2))
    else $error("abort without request");
  a_read_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside slot");
  a_frac_width: assert property (clkEn && regRd && regAddr == 8'hc0 |=> regRdata[31:4] == 28'h0)
    else $error("fraction wider than 4 bits");
  a_take_start: assert property (txQueueTake |-> !serialOut)
    else $error("pop without start bit");
  a_take_once: assert property (txQueueTake |=> !txQueueTake)
    else $error("pop longer than one cycle");
  // with the fastest divisor a bit still lasts 16 cycles
  a_start_hold: assert property ($fell(serialOut) |-> !serialOut [*8])
    else $error("start bit too short");
  a_rx_once: assert property (rxQueueValid |=> !rxQueueValid)
    else $error("receive strobe too long");
endmodule
`default_nettype wire

// ==== una_remote_station.sv ====
`timescale 1ns/100ps
`default_nettype none
// remote station: talks only when told, listens always
module una_remote_station
#(
  parameter int BIT_CYC = 16
)
(
  // clocking
  input wire logic ref_clk,
  // line
  input wire logic lineIn,
  output logic     lineOut,
  // listen for nine data bits
  input wire logic nineBit
);
  logic [8:0] gotChar;
  int         gotCount = 0;
  // line idles high, driven so from time zero
  initial
  begin
    lineOut = 1'b1;
  end
  // start, data lsb first, stop, then one idle bit time
  task automatic send_char(input logic [8:0] ch, input int nb);
    logic [11:0] fr;
    fr = {2'b11, ch, 1'b0};
    fr[nb + 1] = 1'b1;
    for (int i = 0; i <= nb + 2; i++)
      repeat (BIT_CYC) @(posedge ref_clk) lineOut <= fr[i];
  endtask
  // sample each bit in its middle; no stop check, like a lax listener
  always
  begin : listen
    logic [8:0] sh;
    @(negedge lineIn);
    sh = 9'h0;
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < (nineBit ? 9 : 8); i++)
    begin
      repeat (BIT_CYC) @(posedge ref_clk);
      sh[i] = lineIn;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    gotChar = sh;
    gotCount++;
  end
endmodule
`default_nettype wire

// ==== test_una_ext.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_una_ext;
  logic ref_clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic dmaError = 1'b0, txQueueValid = 1'b0, nineRx = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [8:0] txQueueData = 9'h000, rxQueueData, rxLast;
  logic dmaAbort, txQueueTake, rxQueueValid, serialIn, serialOut;
  int mismatches = 0, comparisons = 0, rxCount = 0, abortCount = 0, takeCount = 0, takeMark = 0;
  una_ext dut_u
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .dmaError(dmaError), .dmaAbort(dmaAbort),
    .txQueueData(txQueueData), .txQueueValid(txQueueValid), .txQueueTake(txQueueTake),
    .rxQueueData(rxQueueData), .rxQueueValid(rxQueueValid),
    .serialIn(serialIn), .serialOut(serialOut)
  );
  una_remote_station rs_u
  (
    .ref_clk(ref_clk), .lineIn(serialOut), .lineOut(serialIn), .nineBit(nineRx)
  );
  // 200 MHz
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // count strobes as they happen
  always @(posedge ref_clk)
  begin
    if (rxQueueValid === 1'b1)
    begin
      rxCount++;
      rxLast = rxQueueData;
    end
    if (dmaAbort === 1'b1)
      abortCount++;
    if (txQueueTake === 1'b1)
      takeCount++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one bus slot, changed just after an edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, 1'b0, a, d);
    acc(1'b0, 1'b0, a, d);
  endtask
  // data stand one cycle only, so look just after the slot edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b1, a, 32'h0);
    acc(1'b0, 1'b0, a, 32'h0);
    #1 chk(regRdata, exp);
  endtask
  task automatic tx_wait(input logic [8:0] exp);
    int n;
    n = rs_u.gotCount;
    for (int i = 0; i < 400 && rs_u.gotCount == n; i++)
      @(posedge ref_clk);
    chk(rs_u.gotCount - n, 1);
    chk({23'h0, rs_u.gotChar}, {23'h0, exp});
  endtask
  // offer one queue word until popped, then listen for it
  task automatic tx_queue(input logic [8:0] d, input logic [8:0] exp, input logic nb);
    int k;
    k = takeCount;
    nineRx = nb;
    txQueueData <= d;
    txQueueValid <= 1'b1;
    for (int i = 0; i < 100 && txQueueTake !== 1'b1; i++)
      @(posedge ref_clk);
    txQueueValid <= 1'b0;
    tx_wait(exp);
    chk(takeCount - k, 1);
  endtask
  task automatic rx_send(input logic [8:0] ch, input logic want);
    int n;
    n = rxCount;
    rs_u.send_char(ch, 9);
    chk(rxCount - n, {31'h0, want});
    if (want)
      chk({23'h0, rxLast}, {23'h0, ch});
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hung handshake ends the run here instead
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'ha8, 32'h0);
    rd(8'hcc, 32'h0);
    rd(8'hd0, 32'h1);
    wr(8'hc0, 32'hffff_fffb);
    rd(8'hc0, 32'hb);
    wr(8'hc0, 32'h0);
    // a frozen block ignores a write strobe
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(8'hc0, 32'h5);
    clkEn <= 1'b1;
    rd(8'hc0, 32'h0);
    // read-only and unmapped places ignore writes
    wr(8'hc4, 32'hff);
    wr(8'hc8, 32'hff);
    wr(8'h10, 32'hff);
    rd(8'hc4, 32'h0);
    rd(8'hc8, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'hd4, 32'ha55a);
    rd(8'hc4, 32'h5a);
    rd(8'hc8, 32'ha5);
    // abort pulses once and clears; a zero write does nothing
    dmaError <= 1'b1;
    wr(8'ha8, 32'h1);
    rd(8'hd8, 32'h2);
    rd(8'ha8, 32'h0);
    wr(8'ha8, 32'h0);
    dmaError <= 1'b0;
    chk(abortCount, 1);
    // the bit reads back set for a moment, then clears by itself
    wr(8'ha8, 32'h1);
    rd(8'ha8, 32'h1);
    rd(8'ha8, 32'h0);
    chk(abortCount, 2);
    tx_queue(9'h1a3, 9'h0a3, 1'b0);
    wr(8'hcc, 32'h8);
    tx_queue(9'h13c, 9'h03c, 1'b0);
    wr(8'hcc, 32'h9);
    tx_queue(9'h0c5, 9'h0c5, 1'b1);
    takeMark = takeCount;
    wr(8'hcc, 32'h5);
    tx_wait(9'h1a5);
    chk(takeCount - takeMark, 0);
    wr(8'hcc, 32'h1);
    repeat (400) @(posedge ref_clk);
    // receive plain, then filtered on address 5a
    rx_send(9'h033, 1'b1);
    wr(8'hcc, 32'h3);
    rx_send(9'h011, 1'b0);
    rs_u.send_char(9'h15a, 9);
    rx_send(9'h022, 1'b1);
    rd(8'hd8, 32'h1);
    rs_u.send_char(9'h177, 9);
    rx_send(9'h044, 1'b0);
    wrap_up();
  end
endmodule
bind una_ext una_ext_assertions chk_u
(
  .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dmaAbort(dmaAbort),
  .txQueueTake(txQueueTake), .rxQueueValid(rxQueueValid), .serialOut(serialOut)
);
`default_nettype wire
